// *** udio_core.sv ***
// Purpose: Collects USB and DMA events, masks them and drives the interrupt pin.
// Assumes: Register port and event inputs synchronous to mclk.
// Notes: See behaviour list below.
// Notes on behaviour
// R1 - Software picks pin polarity and level/pulse
// R2 - Reset gives active low, level signalling
// R3 - Pulse mode: fixed pulse on OR rise
// R4 - Each event sets its own status bit
// R5 - Per-source enable gates status onto pin
// R6 - Global enable gates only the pin's rise
// R7 - Three two-bit pipe generation mode fields
// R8 - Global off still records events, no pin
// R9 - Global on with pending asserts pin
// R10 - Clearing global leaves asserted pin asserted
// R11 - Pin drops once pending status cleared
// R12 - Host clears by writing all bytes
// R13 - Sharing mode: pin low, tristate, suspend high
// R14 - Configuration register is one byte
// R15 - DMA reason register is two bytes
// R16 - Status sticky; event beats clear
`timescale 1ns/1ps
`default_nettype none
module udio_core (
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire udio_pkg::udio_req_t req,
  output logic [31:0] reg_rdata,
  input wire logic [udio_pkg::UDIO_USB_W-1:0] usb_evt,
  input wire logic [udio_pkg::UDIO_DMA_W-1:0] dma_evt,
  input wire logic core_power_absent,
  input wire logic suspend_req,
  output logic int_pin,
  output logic io_tristate,
  output logic suspend_ind,
  output udio_pkg::udio_cfg_t pipe_cfg
);
  import udio_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] mode_r, mode_nxt;
  udio_cfg_t cfg_r, cfg_nxt;
  logic [UDIO_USB_W-1:0] usb_en_r, usb_en_nxt, usb_stat_r, usb_stat_nxt;
  logic [UDIO_DMA_W-1:0] dma_en_r, dma_en_nxt, dma_stat_r, dma_stat_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] wmask;
  logic [31:0] clr32;
  logic hit_mode, hit_cfg, hit_usb_en, hit_usb_st, hit_dma_st, hit_dma_en;

  assign hit_mode = req.wr && (req.addr == UDIO_OFS_MODE) && req.be[0];
  assign hit_cfg = req.wr && (req.addr == UDIO_OFS_ICFG) && req.be[0];
  assign hit_usb_en = req.wr && (req.addr == UDIO_OFS_USB_EN);
  assign hit_usb_st = req.wr && (req.addr == UDIO_OFS_USB_STAT);
  assign hit_dma_st = req.wr && (req.addr == UDIO_OFS_DMA_STAT);
  assign hit_dma_en = req.wr && (req.addr == UDIO_OFS_DMA_EN);

  // Byte lanes become a bit mask; a partial clear only touches its lanes
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_lane
      assign wmask[gb*8 +: 8] = {8{req.be[gb]}};
    end
  endgenerate
  assign clr32 = req.wdata & wmask;

  // Next register values; status is write-one-to-clear, events win
  always_comb begin
    mode_nxt = mode_r;
    cfg_nxt = cfg_r;
    usb_en_nxt = usb_en_r;
    dma_en_nxt = dma_en_r;
    usb_stat_nxt = usb_stat_r;
    dma_stat_nxt = dma_stat_r;
    if (hit_mode) begin
      mode_nxt = req.wdata[7:0];
    end
    if (hit_cfg) begin
      cfg_nxt = req.wdata[7:0]; // R1 R7 R14
    end
    if (hit_usb_en) begin
      usb_en_nxt = (usb_en_r & ~wmask) | (req.wdata & wmask);
    end
    if (hit_dma_en) begin
      dma_en_nxt = (dma_en_r & ~wmask[15:0]) | (req.wdata[15:0] & wmask[15:0]);
    end
    if (hit_usb_st) begin
      usb_stat_nxt = usb_stat_nxt & ~clr32;
    end
    if (hit_dma_st) begin
      dma_stat_nxt = dma_stat_nxt & ~clr32[15:0]; // R15
    end
    usb_stat_nxt = usb_stat_nxt | usb_evt; // R4 R16
    dma_stat_nxt = dma_stat_nxt | dma_evt; // R4 R16
  end

  // Read mux, answered one cycle after the strobe; unmapped reads zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (req.rd) begin
      unique case (req.addr)
        UDIO_OFS_MODE: rdata_nxt = {24'h000000, mode_r};
        UDIO_OFS_ICFG: rdata_nxt = {24'h000000, cfg_r}; // R14
        UDIO_OFS_USB_EN: rdata_nxt = usb_en_r;
        UDIO_OFS_USB_STAT: rdata_nxt = usb_stat_r;
        UDIO_OFS_DMA_STAT: rdata_nxt = {16'h0000, dma_stat_r}; // R15
        UDIO_OFS_DMA_EN: rdata_nxt = {16'h0000, dma_en_r};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_r <= UDIO_MODE_RST;
      cfg_r <= UDIO_ICFG_RST; // R2
      usb_en_r <= '0;
      dma_en_r <= '0;
      usb_stat_r <= '0;
      dma_stat_r <= '0;
      rdata_r <= 32'h00000000;
    end else if (ce) begin
      mode_r <= mode_nxt;
      cfg_r <= cfg_nxt;
      usb_en_r <= usb_en_nxt;
      dma_en_r <= dma_en_nxt;
      usb_stat_r <= usb_stat_nxt;
      dma_stat_r <= dma_stat_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign pipe_cfg = cfg_r; // R7

  // ----------------------------------------------------------------
  // Interrupt condition
  // ----------------------------------------------------------------
  logic pending;
  logic global_irq_enable;
  logic irq_act_r, irq_act_nxt;
  logic pulse_trig;
  logic pulse_busy;
  logic pin_act;
  logic int_pin_r, int_pin_nxt;
  logic tri_r, tri_nxt, susp_r, susp_nxt;

  assign pending = |(usb_stat_r & usb_en_r) || |(dma_stat_r & dma_en_r); // R5
  assign global_irq_enable = mode_r[UDIO_GLINT_BIT];

  // Global enable only gates the start; once up, only cleared status or a cleared source enable ends it.
  // This keeps the known sticky behaviour on disable rather than the ideal one.
  always_comb begin
    irq_act_nxt = pending && (global_irq_enable || irq_act_r); // R6 R8 R9 R10 R11
  end

  assign pulse_trig = irq_act_nxt && !irq_act_r && cfg_r.irq_level_or_pulse_sel; // R3

  udio_pulse u_pulse (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .trig(pulse_trig && ce),
    .busy(pulse_busy)
  );

  assign pin_act = cfg_r.irq_level_or_pulse_sel ? pulse_busy : irq_act_r; // R1 R3

  // Pin drivers; sharing mode overrides everything
  always_comb begin
    int_pin_nxt = pin_act ^ ~cfg_r.irq_polarity_sel; // R1 R2
    tri_nxt = 1'b0;
    susp_nxt = suspend_req;
    if (core_power_absent) begin
      int_pin_nxt = 1'b0; // R13
      tri_nxt = 1'b1; // R13
      susp_nxt = 1'b1; // R13
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_act_r <= 1'b0;
      int_pin_r <= 1'b1;
      tri_r <= 1'b0;
      susp_r <= 1'b0;
    end else if (ce) begin
      irq_act_r <= irq_act_nxt;
      int_pin_r <= int_pin_nxt;
      tri_r <= tri_nxt;
      susp_r <= susp_nxt;
    end
  end

  assign int_pin = int_pin_r;
  assign io_tristate = tri_r;
  assign suspend_ind = susp_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_cfg_write;
    ce && hit_cfg;
  endsequence

  a_reset_cfg: assert property (@(posedge mclk) // R2
    srst |=> cfg_r.irq_polarity_sel == 1'b0 && cfg_r.irq_level_or_pulse_sel == 1'b0)
    else $error("config not default after reset");
  a_cfg_byte: assert property (@(posedge mclk) disable iff (srst) // R14
    s_cfg_write |=> cfg_r == $past(req.wdata[7:0]))
    else $error("config byte not stored");
  a_usb_sticky: assert property (@(posedge mclk) disable iff (srst) // R4
    ce |=> (usb_stat_r & $past(usb_evt)) == $past(usb_evt))
    else $error("usb event lost");
  a_dma_sticky: assert property (@(posedge mclk) disable iff (srst) // R16
    ce |=> (dma_stat_r & $past(dma_evt)) == $past(dma_evt))
    else $error("dma event lost");
  a_glob_block: assert property (@(posedge mclk) disable iff (srst) // R8
    ce && !global_irq_enable && !irq_act_r |=> !irq_act_r)
    else $error("pin raised while globally masked");
  a_glob_raise: assert property (@(posedge mclk) disable iff (srst) // R9
    ce && global_irq_enable && pending |=> irq_act_r)
    else $error("pending not raised");
  a_hold_on: assert property (@(posedge mclk) disable iff (srst) // R10
    ce && irq_act_r && pending |=> irq_act_r)
    else $error("pin dropped while pending");
  a_drop_clear: assert property (@(posedge mclk) disable iff (srst) // R11
    ce && !pending |=> !irq_act_r)
    else $error("pin held without cause");
  a_pin_level: assert property (@(posedge mclk) disable iff (srst) // R1
    ce && !core_power_absent && !cfg_r.irq_level_or_pulse_sel
    |=> int_pin_r == ($past(irq_act_r) ^ ~$past(cfg_r.irq_polarity_sel)))
    else $error("pin level wrong");
  a_share_mode: assert property (@(posedge mclk) disable iff (srst) // R13
    ce && core_power_absent |=> !int_pin_r && tri_r && susp_r)
    else $error("sharing mode pins wrong");

endmodule : udio_core
`default_nettype wire

// *** udio_pkg.sv ***
// Purpose: Shared constants and types for the interrupt output block.
// Assumes: 250 MHz mclk, byte-addressed register port with 32-bit data.
// Notes: Every offset, field position, width, the mode and config reset values and the pulse count live here.
`default_nettype none
package udio_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] UDIO_OFS_MODE = 8'h0C;
  localparam logic [7:0] UDIO_OFS_ICFG = 8'h10;
  localparam logic [7:0] UDIO_OFS_USB_EN = 8'h14;
  localparam logic [7:0] UDIO_OFS_USB_STAT = 8'h18;
  localparam logic [7:0] UDIO_OFS_DMA_STAT = 8'h50;
  localparam logic [7:0] UDIO_OFS_DMA_EN = 8'h54;

  // ----------------------------------------------------------------
  // Widths, field positions and reset values
  // ----------------------------------------------------------------
  localparam int UDIO_USB_W = 32;
  localparam int UDIO_DMA_W = 16;
  localparam int UDIO_GLINT_BIT = 3;
  localparam logic [7:0] UDIO_MODE_RST = 8'h00;
  localparam logic [7:0] UDIO_ICFG_RST = 8'h00;

  // ----------------------------------------------------------------
  // Pulse timing
  // ----------------------------------------------------------------
  localparam int UDIO_CLK_PS = 4000;
  localparam int UDIO_PULSE_PS = 60000;
  localparam int UDIO_PULSE_CYC_I = (UDIO_PULSE_PS + UDIO_CLK_PS - 1) / UDIO_CLK_PS;
  localparam logic [4:0] UDIO_PULSE_CYC = 5'(UDIO_PULSE_CYC_I);

  // Interrupt configuration byte, msb first
  typedef struct packed {
    logic [1:0] control_pipe_irq_mode;
    logic [1:0] in_pipe_irq_mode;
    logic [1:0] out_pipe_irq_mode;
    logic irq_level_or_pulse_sel;
    logic irq_polarity_sel;
  } udio_cfg_t;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } udio_req_t;

endpackage : udio_pkg
`default_nettype wire

// *** udio_pulse.sv ***
// Purpose: Fixed-width pulse former for the pulse signalling style.
// Assumes: trig is a one-cycle request from the core.
// Notes: A new trigger while busy restarts the full width.
`timescale 1ns/1ps
`default_nettype none
module udio_pulse (
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire logic trig,
  output logic busy
);
  import udio_pkg::*;

  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;

  // Count down the pulse width
  always_comb begin
    cnt_nxt = cnt_r;
    if (trig) begin
      cnt_nxt = UDIO_PULSE_CYC; // R3
    end else if (cnt_r != 5'h00) begin
      cnt_nxt = cnt_r - 5'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_r <= 5'h00;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
    end
  end

  assign busy = (cnt_r != 5'h00);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_pulse_load: assert property (@(posedge mclk) disable iff (srst) // R3
    ce && trig |=> cnt_r == UDIO_PULSE_CYC)
    else $error("pulse width not loaded");
  a_pulse_end: assert property (@(posedge mclk) disable iff (srst) // R3
    $fell(busy) |-> $past(cnt_r) == 5'h01)
    else $error("pulse ended early");

endmodule : udio_pulse
`default_nettype wire

// *** udio_host_model.sv ***
// Purpose: Firmware host model that drives the register port of the block.
// Assumes: Requests launch on the falling edge and are taken on the next rising edge.
// Notes: Released write data is inverted so a stale value never looks valid.
`timescale 1ns/1ps
`default_nettype none
module udio_host_model (
  input wire logic mclk,
  output var udio_pkg::udio_req_t req,
  input wire logic [31:0] reg_rdata
);
  import udio_pkg::*;
  initial req = '0;
  // One write strobe, held across exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge mclk);
    req.wr = 1'b1;
    req.addr = a;
    req.be = be;
    req.wdata = d;
    @(negedge mclk);
    req.wr = 1'b0;
    req.wdata = ~d; // Bus released
  endtask : wr
  // Status clears always write every byte lane
  task automatic clr(input logic [7:0] a);
    wr(a, 4'hF, 32'hFFFFFFFF);
  endtask : clr
  // Read strobe, data taken one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(negedge mclk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge mclk);
    req.rd = 1'b0;
    @(negedge mclk);
    q = reg_rdata;
  endtask : rd
endmodule : udio_host_model
`default_nettype wire

// *** tb_usb_device_interrupt_output.sv ***
// Purpose: Self-checking bench for the interrupt output block.
// Assumes: Inputs change on the falling edge; clock enable low only in the freeze scenario.
// Notes: Each scenario is its own task and judges its own results.
`timescale 1ns/1ps
`default_nettype none
module tb_usb_device_interrupt_output;
  import udio_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [31:0] usb_evt = '0;
  logic [15:0] dma_evt = '0;
  logic core_power_absent = 1'b0;
  logic suspend_req = 1'b0;
  logic ce = 1'b1;
  udio_req_t req;
  logic [31:0] reg_rdata;
  logic [31:0] q;
  logic int_pin;
  logic io_tristate;
  logic suspend_ind;
  udio_cfg_t pipe_cfg;
  int n_mismatch = 0;
  int checks_done = 0;
  int hi;
  always #2 mclk = ~mclk;
  udio_core udio_core_i (.mclk(mclk), .srst(srst), .ce(ce), .req(req), .reg_rdata(reg_rdata),
    .usb_evt(usb_evt), .dma_evt(dma_evt), .core_power_absent(core_power_absent),
    .suspend_req(suspend_req), .int_pin(int_pin), .io_tristate(io_tristate),
    .suspend_ind(suspend_ind), .pipe_cfg(pipe_cfg));
  udio_host_model udio_host_model_i (.mclk(mclk), .req(req), .reg_rdata(reg_rdata));
  // Single comparison point, four-state exact
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  // One-cycle event pulse on the USB or DMA inputs
  task automatic ev(input logic [31:0] u, input logic [15:0] d);
    @(negedge mclk);
    usb_evt = u;
    dma_evt = d;
    @(negedge mclk);
    usb_evt = '0;
    dma_evt = '0;
  endtask : ev
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    udio_host_model_i.rd(a, q);
    chk(what, q, exp);
  endtask : rdchk
  task automatic t_reset();
    chk("idle pin", int_pin, 1'b1);
    rdchk("mode", UDIO_OFS_MODE, 32'h0);
    rdchk("config", UDIO_OFS_ICFG, 32'h0);
    rdchk("unmapped", 8'h20, 32'h0);
  endtask : t_reset
  // Masked event is recorded, then released by the global enable
  task automatic t_global();
    udio_host_model_i.wr(UDIO_OFS_USB_EN, 4'hF, 32'h1);
    ev(32'h21, '0);
    repeat (4) @(negedge mclk);
    chk("pin global off", int_pin, 1'b1);
    rdchk("usb status", UDIO_OFS_USB_STAT, 32'h21);
    rdchk("unmapped after data", 8'h20, 32'h0);
    udio_host_model_i.wr(UDIO_OFS_MODE, 4'hF, 32'h8);
    repeat (3) @(negedge mclk);
    chk("pin global on", int_pin, 1'b0);
    udio_host_model_i.wr(UDIO_OFS_MODE, 4'hF, 32'h0);
    repeat (3) @(negedge mclk);
    chk("pin after global off", int_pin, 1'b0);
    udio_host_model_i.clr(UDIO_OFS_USB_STAT);
    repeat (3) @(negedge mclk);
    chk("pin after clear", int_pin, 1'b1);
    udio_host_model_i.wr(UDIO_OFS_MODE, 4'hF, 32'h8);
    ev(32'h20, '0);
    repeat (4) @(negedge mclk);
    chk("disabled source", int_pin, 1'b1);
  endtask : t_global
  // Event in the same cycle as a full clear survives the clear
  task automatic t_race();
    fork
      udio_host_model_i.clr(UDIO_OFS_USB_STAT);
      ev(32'h1, '0);
    join
    rdchk("event beats clear", UDIO_OFS_USB_STAT, 32'h1);
    udio_host_model_i.clr(UDIO_OFS_USB_STAT);
    rdchk("status cleared", UDIO_OFS_USB_STAT, 32'h0);
  endtask : t_race
  // Clock enable low freezes state: a write and an event are both lost
  task automatic t_freeze();
    ce = 1'b0;
    udio_host_model_i.wr(UDIO_OFS_MODE, 4'hF, 32'h0);
    ev(32'h1, '0);
    ce = 1'b1;
    rdchk("mode frozen", UDIO_OFS_MODE, 32'h8);
    rdchk("status frozen", UDIO_OFS_USB_STAT, 32'h0);
    // A mode write without its low byte lane is refused
    udio_host_model_i.wr(UDIO_OFS_MODE, 4'hE, 32'h0);
    rdchk("mode lane refused", UDIO_OFS_MODE, 32'h8);
  endtask : t_freeze
  // Top bit of the two-byte DMA reason register
  task automatic t_dma();
    udio_host_model_i.wr(UDIO_OFS_DMA_EN, 4'hF, 32'h8000);
    ev('0, 16'h8000);
    repeat (4) @(negedge mclk);
    chk("dma pin", int_pin, 1'b0);
    rdchk("dma reason", UDIO_OFS_DMA_STAT, 32'h8000);
    udio_host_model_i.clr(UDIO_OFS_DMA_STAT);
    repeat (3) @(negedge mclk);
    chk("dma pin cleared", int_pin, 1'b1);
  endtask : t_dma
  // Active-high pulse: fixed width once per rise of the OR of the enabled bits
  task automatic t_pulse();
    udio_host_model_i.wr(UDIO_OFS_ICFG, 4'hF, 32'hE7);
    @(negedge mclk);
    chk("pipe fields", pipe_cfg, 8'hE7);
    chk("active high idle", int_pin, 1'b0);
    udio_host_model_i.wr(UDIO_OFS_USB_EN, 4'hF, 32'h3);
    for (int k = 0; k < 2; k++) begin
      ev(32'h1 << k, '0);
      hi = 0;
      repeat (30) begin
        @(negedge mclk);
        hi += int'(int_pin === 1'b1);
      end
      chk("pulse cycles", hi, k ? 0 : int'(UDIO_PULSE_CYC));
    end
    udio_host_model_i.clr(UDIO_OFS_USB_STAT);
  endtask : t_pulse
  // Sharing mode entered from an idle active-low pin, then left again
  task automatic t_share();
    udio_host_model_i.wr(UDIO_OFS_ICFG, 4'hF, 32'h0);
    suspend_req = 1'b1;
    @(negedge mclk);
    chk("idle pin high", int_pin, 1'b1);
    chk("normal tristate", io_tristate, 1'b0);
    chk("normal suspend", suspend_ind, 1'b1);
    suspend_req = 1'b0;
    core_power_absent = 1'b1;
    repeat (2) @(negedge mclk);
    chk("share pin", int_pin, 1'b0);
    chk("share tristate", io_tristate, 1'b1);
    chk("share suspend", suspend_ind, 1'b1);
    core_power_absent = 1'b0;
    repeat (2) @(negedge mclk);
    chk("pin after share", int_pin, 1'b1);
    chk("tristate after share", io_tristate, 1'b0);
    chk("suspend after share", suspend_ind, 1'b0);
  endtask : t_share
  // Watchdog sized well past the whole sequence
  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (20) @(negedge mclk);
    srst = 1'b0;
    t_reset();
    t_global();
    t_race();
    t_freeze();
    t_dma();
    t_pulse();
    t_share();
    give_verdict();
  end
endmodule : tb_usb_device_interrupt_output
`default_nettype wire
